// [verilog/pwd_map.svh]
`ifndef PWD_MAP_SVH
`define PWD_MAP_SVH

// ----------------------------------------------------------------------
// Time base
// ----------------------------------------------------------------------
// Core clock rate in MHz, so one microsecond is this many cycles.
`define PWD_CLK_MHZ 100
// Width of the shared interval counter; 96 ms needs 24 bits.
`define PWD_CNT_W 24

// ----------------------------------------------------------------------
// Intervals in microseconds, typical figures
// ----------------------------------------------------------------------
`define PWD_RST_DLY_SLOW_US 16500
`define PWD_RST_DLY_FAST_US 8500
`define PWD_IGNORE_US 16000
`define PWD_PERIOD_96_US 96000
`define PWD_PERIOD_48_US 48000
`define PWD_PERIOD_32_US 32000
`define PWD_PERIOD_16_US 16000
`define PWD_ALARM_LOW_US 8000
`define PWD_DIS_FILT_MIN_US 100
`define PWD_DIS_FILT_MAX_US 500
`define PWD_DIS_FILT_US 300
`define PWD_STRAP_HOLD_US 150

// ----------------------------------------------------------------------
// Interval lengths in core clock cycles
// ----------------------------------------------------------------------
`define PWD_RST_DLY_SLOW_CYC 24'(`PWD_RST_DLY_SLOW_US * `PWD_CLK_MHZ)
`define PWD_RST_DLY_FAST_CYC 24'(`PWD_RST_DLY_FAST_US * `PWD_CLK_MHZ)
`define PWD_IGNORE_CYC 24'(`PWD_IGNORE_US * `PWD_CLK_MHZ)
`define PWD_PERIOD_96_CYC 24'(`PWD_PERIOD_96_US * `PWD_CLK_MHZ)
`define PWD_PERIOD_48_CYC 24'(`PWD_PERIOD_48_US * `PWD_CLK_MHZ)
`define PWD_PERIOD_32_CYC 24'(`PWD_PERIOD_32_US * `PWD_CLK_MHZ)
`define PWD_PERIOD_16_CYC 24'(`PWD_PERIOD_16_US * `PWD_CLK_MHZ)
`define PWD_ALARM_LOW_CYC 24'(`PWD_ALARM_LOW_US * `PWD_CLK_MHZ)
`define PWD_DIS_FILT_CYC 24'(`PWD_DIS_FILT_US * `PWD_CLK_MHZ)
`define PWD_STRAP_HOLD_CYC 24'(`PWD_STRAP_HOLD_US * `PWD_CLK_MHZ)

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PWD_CNT_RST 24'h00_0000
`define PWD_SYNC_RST 5'h00

`endif

// [verilog/pwd_pkg.sv]
`include "pwd_map.svh"

package pwd_pkg;

    // ------------------------------------------------------------------
    // Watchdog states, Gray coded along the usual path.
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PWD_RST_DLY = 3'h0,
        PWD_IGNORE = 3'h1,
        PWD_TRIGGER = 3'h3,
        PWD_ALARM = 3'h2,
        PWD_WAIT_HIGH = 3'h6,
        PWD_DISABLED = 3'h7
    } pwd_state_t;

    // ------------------------------------------------------------------
    // Trigger period selection, coded as {select_b, select_a}.
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PWD_PER_96 = 2'h0,
        PWD_PER_48 = 2'h1,
        PWD_PER_32 = 2'h2,
        PWD_PER_16 = 2'h3
    } pwd_period_t;

    typedef logic [`PWD_CNT_W-1:0] pwd_count_t;

endpackage

// [verilog/pwd_sync.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pwd_map.svh"

// ----------------------------------------------------------------------
// Two-stage synchroniser for a group of pin levels
// ----------------------------------------------------------------------
module pwd_sync
(
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Asynchronous levels and their synchronised copies.
    input wire logic [4:0] async_in,
    output logic [4:0] sync_out
);

    logic [4:0] meta_reg;
    logic [4:0] sync_reg;

    // Only the second stage may be read; the first can be metastable.
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            meta_reg <= `PWD_SYNC_RST;
            sync_reg <= `PWD_SYNC_RST;
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule

`default_nettype wire

// [verilog/pwd_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pwd_map.svh"

// What this block does
// (R1) No trigger within period pulls alarm low.
// (R2) Intervals from own clock; straps pick period.
// (R3) Alarm separate from reset; both drive low.
// (R4) New strap period applies from next period.
// (R5) Reset held low for reset delay.
// (R6) Alarm release starts the ignore interval.
// (R7) Ignore expiry starts trigger period timing.
// (R8) Falling trigger edge restarts period, no alarm.
// (R9) Controller triggers fast enough for period.
// (R10) Straps select 96, 48, 32, 16 ms.
// (R11) Alarm held low 8 ms then released.
// (R12) Alarm is open drain, pulled up.
// (R13) Controller holds trigger phases at least 1 us.
// (R14) Disable band level disables the watchdog.
// (R15) Disable filter: ignore short, act on long.
// (R16) Leaving disable restarts with ignore interval.
// (R17) Disabled keeps alarm high after running alarm.
// (R18) Strap changes near period boundary are ignored.
// (R19) Trigger synchronised; one edge, one restart.
// (R20) Watchdog idle until reset delay ends.
module pwd_top
    import pwd_pkg::*;
#(
    parameter pwd_count_t RST_DLY_SLOW_CYC = `PWD_RST_DLY_SLOW_CYC,
    parameter pwd_count_t RST_DLY_FAST_CYC = `PWD_RST_DLY_FAST_CYC,
    parameter pwd_count_t IGNORE_CYC = `PWD_IGNORE_CYC,
    parameter pwd_count_t PERIOD_96_CYC = `PWD_PERIOD_96_CYC,
    parameter pwd_count_t PERIOD_48_CYC = `PWD_PERIOD_48_CYC,
    parameter pwd_count_t PERIOD_32_CYC = `PWD_PERIOD_32_CYC,
    parameter pwd_count_t PERIOD_16_CYC = `PWD_PERIOD_16_CYC,
    parameter pwd_count_t ALARM_LOW_CYC = `PWD_ALARM_LOW_CYC,
    parameter pwd_count_t DIS_FILT_CYC = `PWD_DIS_FILT_CYC,
    parameter pwd_count_t STRAP_HOLD_CYC = `PWD_STRAP_HOLD_CYC
)
(
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Trigger pin and its disable band comparator.
    input wire logic trigger_in,
    input wire logic trigger_disable_in,
    // Period select straps.
    input wire logic period_select_a_in,
    input wire logic period_select_b_in,
    // Open-drain alarm pin.
    input wire logic alarm_out_n_in,
    output logic alarm_out_n_out,
    output logic alarm_out_n_oe_out,
    // Open-drain reset pin.
    output logic reset_out_n_out,
    output logic reset_out_n_oe_out
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [4:0] pins_sync;
    logic trig_sync;
    logic dis_sync;
    logic sela_sync;
    logic selb_sync;
    logic alarm_pin_sync;

    logic trig_prev_reg;
    logic trig_fall;

    logic dis_state_reg;
    logic dis_state_next;
    pwd_count_t dis_cnt_reg;
    pwd_count_t dis_cnt_next;
    logic dis_filt_done;

    pwd_period_t strap_pair;
    pwd_period_t strap_cand_reg;
    pwd_period_t strap_ok_reg;
    pwd_period_t strap_ok_next;
    pwd_count_t strap_cnt_reg;
    pwd_count_t strap_cnt_next;
    logic strap_held;

    pwd_period_t period_reg;
    pwd_period_t period_next;
    pwd_count_t period_len;
    pwd_count_t rst_dly_len;

    pwd_state_t state_reg;
    pwd_state_t state_next;
    pwd_count_t cnt_reg;
    pwd_count_t cnt_next;

    logic alarm_oe_reg;
    logic reset_oe_reg;

    // ------------------------------------------------------------------
    // Period decoding
    // ------------------------------------------------------------------
    // Typical trigger period for a strap setting.
    function automatic pwd_count_t period_cycles(input pwd_period_t sel);
        pwd_count_t len;
        case (sel)
            PWD_PER_96: len = PERIOD_96_CYC; // R10
            PWD_PER_48: len = PERIOD_48_CYC; // R10
            PWD_PER_32: len = PERIOD_32_CYC; // R10
            PWD_PER_16: len = PERIOD_16_CYC; // R10
            default: len = PERIOD_96_CYC;
        endcase
        return len;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    // Every pin level passes two flip-flops before use.
    pwd_sync u_sync
    (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .async_in({alarm_out_n_in, period_select_b_in,
                   period_select_a_in, trigger_disable_in, trigger_in}),
        .sync_out(pins_sync)
    );

    assign trig_sync = pins_sync[0]; // R19
    assign dis_sync = pins_sync[1];
    assign sela_sync = pins_sync[2];
    assign selb_sync = pins_sync[3];
    assign alarm_pin_sync = pins_sync[4];

    // ------------------------------------------------------------------
    // Trigger edge detection
    // ------------------------------------------------------------------
    // One cycle of history gives exactly one pulse per falling edge.
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            trig_prev_reg <= 1'b0;
        else
            trig_prev_reg <= trig_sync;
    end

    assign trig_fall = trig_prev_reg & ~trig_sync; // R19

    // ------------------------------------------------------------------
    // Disable band filter
    // ------------------------------------------------------------------
    // The filtered state flips only after the new level has stood for
    // the whole filter time, so short glitches are lost on purpose.
    assign dis_filt_done = (dis_cnt_reg == DIS_FILT_CYC - 24'h00_0001);
    assign dis_cnt_next = (dis_sync == dis_state_reg || dis_filt_done)
                          ? `PWD_CNT_RST
                          : dis_cnt_reg + 24'h00_0001; // R15
    assign dis_state_next = (dis_sync != dis_state_reg && dis_filt_done)
                            ? dis_sync : dis_state_reg; // R14

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            dis_state_reg <= 1'b0;
            dis_cnt_reg <= `PWD_CNT_RST;
        end
        else
        begin
            dis_state_reg <= dis_state_next;
            dis_cnt_reg <= dis_cnt_next;
        end
    end

    // ------------------------------------------------------------------
    // Strap qualification
    // ------------------------------------------------------------------
    // A strap pair counts only once it has been steady for the hold
    // time, so a change just before a period boundary is not taken.
    assign strap_pair = pwd_period_t'({selb_sync, sela_sync});
    assign strap_held = (strap_cnt_reg == STRAP_HOLD_CYC);
    assign strap_cnt_next = (strap_pair != strap_cand_reg)
                            ? `PWD_CNT_RST
                            : (strap_held ? strap_cnt_reg
                                          : strap_cnt_reg + 24'h00_0001);
    assign strap_ok_next = strap_held ? strap_cand_reg
                                      : strap_ok_reg; // R18

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            strap_cand_reg <= PWD_PER_96;
            strap_ok_reg <= PWD_PER_96;
            strap_cnt_reg <= `PWD_CNT_RST;
        end
        else
        begin
            strap_cand_reg <= strap_pair;
            strap_ok_reg <= strap_ok_next;
            strap_cnt_reg <= strap_cnt_next;
        end
    end

    // ------------------------------------------------------------------
    // Interval lengths
    // ------------------------------------------------------------------
    // The active period is latched at each period start and nowhere
    // else, so a strap change never stretches a running period.
    assign period_len = period_cycles(period_reg); // R2
    assign rst_dly_len = sela_sync ? RST_DLY_FAST_CYC : RST_DLY_SLOW_CYC;

    // ------------------------------------------------------------------
    // Watchdog sequencer
    // ------------------------------------------------------------------
    // One counter serves every sequencer interval; it clears on each state entry.
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg + 24'h00_0001;
        period_next = period_reg;
        case (state_reg)
            PWD_RST_DLY:
            begin
                // Nothing is watched until the reset delay is over.
                if (cnt_reg >= rst_dly_len - 24'h00_0001) // R20
                begin
                    state_next = PWD_IGNORE; // R5
                    cnt_next = `PWD_CNT_RST;
                end
            end
            PWD_IGNORE:
            begin
                if (dis_state_reg)
                begin
                    state_next = PWD_DISABLED; // R14
                    cnt_next = `PWD_CNT_RST;
                end
                else if (cnt_reg == IGNORE_CYC - 24'h00_0001)
                begin
                    state_next = PWD_TRIGGER; // R7
                    cnt_next = `PWD_CNT_RST;
                    period_next = strap_ok_reg; // R4
                end
            end
            PWD_TRIGGER:
            begin
                if (dis_state_reg)
                begin
                    state_next = PWD_DISABLED; // R14
                    cnt_next = `PWD_CNT_RST;
                end
                else if (trig_fall)
                begin
                    cnt_next = `PWD_CNT_RST; // R8
                    period_next = strap_ok_reg; // R4
                end
                else if (cnt_reg == period_len - 24'h00_0001)
                begin
                    state_next = PWD_ALARM; // R1
                    cnt_next = `PWD_CNT_RST;
                end
            end
            PWD_ALARM:
            begin
                // The low time always runs out, disabled or not.
                if (cnt_reg == ALARM_LOW_CYC - 24'h00_0001) // R17
                begin
                    state_next = PWD_WAIT_HIGH; // R11
                    cnt_next = `PWD_CNT_RST;
                end
            end
            PWD_WAIT_HIGH:
            begin
                // Wait for the pin to really rise; a wired-OR partner
                // may still hold it low.
                cnt_next = `PWD_CNT_RST;
                if (alarm_pin_sync)
                    state_next = dis_state_reg ? PWD_DISABLED
                                               : PWD_IGNORE; // R6
            end
            PWD_DISABLED:
            begin
                cnt_next = `PWD_CNT_RST;
                if (!dis_state_reg)
                    state_next = PWD_IGNORE; // R16
            end
            default:
            begin
                state_next = PWD_RST_DLY;
                cnt_next = `PWD_CNT_RST;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_reg <= PWD_RST_DLY;
            cnt_reg <= `PWD_CNT_RST;
            period_reg <= PWD_PER_96;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            period_reg <= period_next;
        end
    end

    // ------------------------------------------------------------------
    // Open-drain pin drivers
    // ------------------------------------------------------------------
    // Enables come from flip-flops so the pins never glitch low.
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            alarm_oe_reg <= 1'b0;
            reset_oe_reg <= 1'b1;
        end
        else
        begin
            alarm_oe_reg <= (state_next == PWD_ALARM); // R1
            reset_oe_reg <= (state_next == PWD_RST_DLY); // R5
        end
    end

    // Both pins only ever pull low; the pull-up makes the high level.
    assign alarm_out_n_out = 1'b0; // R12
    assign alarm_out_n_oe_out = alarm_oe_reg; // R3
    assign reset_out_n_out = 1'b0; // R3
    assign reset_out_n_oe_out = reset_oe_reg;

endmodule

`default_nettype wire

// [testbench/pwd_top_assertions.sv]
`timescale 1ns/1ns
`default_nettype none

// ----------
// Port checks
// ----------
module pwd_top_assertions
    import pwd_pkg::*;
#(
    parameter pwd_count_t RST_DLY_SLOW_CYC = 24'h00_0001,
    parameter pwd_count_t RST_DLY_FAST_CYC = 24'h00_0001,
    parameter pwd_count_t IGNORE_CYC = 24'h00_0001,
    parameter pwd_count_t PERIOD_16_CYC = 24'h00_0001,
    parameter pwd_count_t ALARM_LOW_CYC = 24'h00_0001,
    parameter pwd_count_t DIS_FILT_CYC = 24'h00_0001
)
(
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Pin inputs.
    input wire logic trigger_in,
    input wire logic trigger_disable_in,
    input wire logic period_select_a_in,
    input wire logic period_select_b_in,
    input wire logic alarm_out_n_in,
    // Pin drivers.
    input wire logic alarm_out_n_out,
    input wire logic alarm_out_n_oe_out,
    input wire logic reset_out_n_out,
    input wire logic reset_out_n_oe_out
);
    pwd_count_t alm_len_reg;
    pwd_count_t rst_len_reg;
    pwd_count_t gap_reg;
    pwd_count_t age_reg;
    pwd_count_t dis_reg;
    pwd_count_t rst_want;
    logic trig_last_reg;

    // The reset delay follows strap a, which stays put during reset.
    assign rst_want = period_select_a_in ? RST_DLY_FAST_CYC : RST_DLY_SLOW_CYC;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    function automatic pwd_count_t sat(input pwd_count_t v);
        return (v == 24'hff_ffff) ? v : v + 24'h00_0001;
    endfunction

    // Counters saturate, so a long quiet spell never looks fresh.
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            alm_len_reg <= 24'h00_0000;
            rst_len_reg <= 24'h00_0000;
            gap_reg <= 24'h00_0000;
            age_reg <= 24'h00_0000;
            dis_reg <= 24'h00_0000;
            trig_last_reg <= 1'b1;
        end
        else
        begin
            alm_len_reg <= alarm_out_n_oe_out ? sat(alm_len_reg) : 24'h00_0000;
            rst_len_reg <= reset_out_n_oe_out ? sat(rst_len_reg) : 24'h00_0000;
            gap_reg <= (alarm_out_n_oe_out || reset_out_n_oe_out) ?
                24'h00_0000 : sat(gap_reg);
            age_reg <= (trig_last_reg && !trigger_in) ?
                24'h00_0000 : sat(age_reg);
            dis_reg <= trigger_disable_in ? sat(dis_reg) : 24'h00_0000;
            trig_last_reg <= trigger_in;
        end
    end

    property p_low_only;
        !alarm_out_n_out && !reset_out_n_out;
    endproperty
    a_low_only: assert property (p_low_only)
        else $error("pin drive value is not low");

    property p_indep;
        alarm_out_n_oe_out |-> !reset_out_n_oe_out;
    endproperty
    a_indep: assert property (p_indep)
        else $error("alarm and reset pulled together");

    property p_alarm_len;
        $fell(alarm_out_n_oe_out) |-> alm_len_reg == ALARM_LOW_CYC;
    endproperty
    a_alarm_len: assert property (p_alarm_len)
        else $error("alarm low time wrong");

    property p_alarm_max;
        alarm_out_n_oe_out |-> alm_len_reg < ALARM_LOW_CYC;
    endproperty
    a_alarm_max: assert property (p_alarm_max)
        else $error("alarm held too long");

    property p_rst_len;
        $fell(reset_out_n_oe_out) |->
            rst_len_reg >= rst_want && rst_len_reg <= rst_want + 24'h00_0001;
    endproperty
    a_rst_len: assert property (p_rst_len)
        else $error("reset delay wrong");

    property p_rearm;
        $rose(alarm_out_n_oe_out) |->
            gap_reg + 24'h00_0002 >= IGNORE_CYC + PERIOD_16_CYC;
    endproperty
    a_rearm: assert property (p_rearm)
        else $error("alarm inside ignore interval");

    property p_restart;
        $rose(alarm_out_n_oe_out) |-> age_reg >= PERIOD_16_CYC;
    endproperty
    a_restart: assert property (p_restart)
        else $error("alarm too soon after trigger");

    property p_disabled;
        $rose(alarm_out_n_oe_out) |-> dis_reg <= DIS_FILT_CYC + 24'h00_0004;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("alarm while disabled");
endmodule

`default_nettype wire

// [testbench/pwd_mcu_model.sv]
`timescale 1ns/1ns
`default_nettype none

// ----------
// Controller serving the trigger pin
// ----------
module pwd_mcu_model
(
    // Clock.
    input wire logic core_clk_in,
    // Serve or stall, and the half period in cycles.
    input wire logic serve_in,
    input wire logic [15:0] half_in,
    // Trigger pin.
    output var logic trigger_out
);
    logic [15:0] cnt_reg = 16'h0000;
    logic go_reg = 1'b0;

    initial
        trigger_out = 1'b1;

    // A stall holds the level, as a hung controller would. Phases never
    // drop under 100 cycles, so no edge is lost in the pin filter.
    always @(posedge core_clk_in)
    begin
        go_reg = serve_in;
        #1;
        if (!go_reg)
            cnt_reg = 16'h0000;
        else if (cnt_reg + 16'h0001 >= half_in
                 && cnt_reg >= 16'h0063)
        begin
            cnt_reg = 16'h0000;
            trigger_out = !trigger_out;
        end
        else
            cnt_reg = cnt_reg + 16'h0001;
    end
endmodule

`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_top import pwd_pkg::*;;
    // ----------
    // Shortened intervals
    // ----------
    localparam pwd_count_t T_RS = 24'h00_0320;
    localparam pwd_count_t T_RF = 24'h00_0258;
    localparam pwd_count_t T_IG = 24'h00_02bc;
    localparam pwd_count_t T_P96 = 24'h00_07d0;
    localparam pwd_count_t T_P48 = 24'h00_05dc;
    localparam pwd_count_t T_P32 = 24'h00_03e8;
    localparam pwd_count_t T_P16 = 24'h00_01f4;
    localparam pwd_count_t T_AL = 24'h00_012c;
    localparam pwd_count_t T_FI = 24'h00_00c8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic trig;
    logic dis = 1'b0;
    logic sel_a = 1'b0;
    logic sel_b = 1'b0;
    logic alarm_pin_n;
    logic alm_drv, alm_oe, rst_drv, rst_oe;
    logic serve = 1'b0;
    logic [15:0] half = 16'h0064;
    logic trig_prev = 1'b1;
    logic oe_prev = 1'b0;
    int n_fail = 0;
    int tests_run = 0;
    int cyc_cnt = 0;
    int t_fall = 0;
    int n_rise = 0;

    // The alarm wire rises through its pull-up when nobody pulls it.
    assign alarm_pin_n = !alm_oe;
    always #5 clk = !clk;

    pwd_top #(.RST_DLY_SLOW_CYC(T_RS), .RST_DLY_FAST_CYC(T_RF),
        .IGNORE_CYC(T_IG), .PERIOD_96_CYC(T_P96), .PERIOD_48_CYC(T_P48),
        .PERIOD_32_CYC(T_P32), .PERIOD_16_CYC(T_P16), .ALARM_LOW_CYC(T_AL),
        .DIS_FILT_CYC(T_FI), .STRAP_HOLD_CYC(24'h00_0064)) pwd_top_i (
        .core_clk_in(clk), .rst_in(rst), .trigger_in(trig),
        .trigger_disable_in(dis), .period_select_a_in(sel_a),
        .period_select_b_in(sel_b), .alarm_out_n_in(alarm_pin_n),
        .alarm_out_n_out(alm_drv), .alarm_out_n_oe_out(alm_oe),
        .reset_out_n_out(rst_drv), .reset_out_n_oe_out(rst_oe));
    pwd_mcu_model pwd_mcu_model_i (.core_clk_in(clk), .serve_in(serve),
        .half_in(half), .trigger_out(trig));

    // Pin monitor: times the last trigger fall, counts alarm starts.
    always @(posedge clk)
    begin
        cyc_cnt++;
        if (trig_prev === 1'b1 && trig === 1'b0)
            t_fall = cyc_cnt;
        if (oe_prev === 1'b0 && alm_oe === 1'b1)
            n_rise++;
        trig_prev = trig;
        oe_prev = alm_oe;
    end

    function automatic int per_of(input logic [1:0] c);
        case (c)
            2'h0: return int'(T_P96);
            2'h1: return int'(T_P48);
            2'h2: return int'(T_P32);
            default: return int'(T_P16);
        endcase
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check_range(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi)
        begin
            $display("[ERR] %0t got %0d not in %0d..%0d", $time, got, lo, hi);
            n_fail++;
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("[ERR] %0t level %b, want %b", $time, got, exp);
            n_fail++;
        end
    endtask

    // Bounded wait for the alarm pull-down to reach a level.
    task automatic wait_oe(input logic lvl, input int lim, output int t);
        int i;
        i = 0;
        while (alm_oe !== lvl && i < lim)
        begin
            cyc(1);
            i++;
        end
        check_bit(alm_oe, lvl);
        t = cyc_cnt;
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        #1_000_000;
        $display("[ERR] %0t run took too long", $time);
        n_fail++;
        conclude();
    end

    initial
    begin
        int p, t_r, t_f, t0, start, seen, ig;
        void'($urandom(60159));
        ig = int'(T_IG);
        cyc(16);
        rst = 1'b0;
        t0 = cyc_cnt;
        check_bit(alm_oe, 1'b0);
        while (rst_oe !== 1'b0 && cyc_cnt - t0 < 2000)
            cyc(1);
        check_range(cyc_cnt - t0, int'(T_RS), int'(T_RS) + 3);
        half = 16'(100 + $urandom_range(100));
        serve = 1'b1;
        seen = n_rise;
        cyc(6000);
        check_range(n_rise - seen, 0, 0);
        // Every strap code: served, then stalled into two alarms.
        start = $urandom_range(3);
        for (int k = 0; k < 4; k++)
        begin
            {sel_b, sel_a} = 2'(start + k);
            half = 16'(100 + $urandom_range(100));
            serve = 1'b1;
            cyc(int'(T_P96) * 2 + 500);
            p = per_of({sel_b, sel_a});
            serve = 1'b0;
            wait_oe(1'b1, p + 50, t_r);
            check_range(t_r - t_fall, p, p + 4);
            wait_oe(1'b0, int'(T_AL) + 50, t_f);
            check_range(t_f - t_r, int'(T_AL), int'(T_AL));
            wait_oe(1'b1, ig + p + 50, t_r);
            check_range(t_r - t_f, ig + p, ig + p + 6);
            wait_oe(1'b0, int'(T_AL) + 50, t_f);
        end
        // Short disable is ignored, long disable holds the pin high.
        serve = 1'b1;
        cyc(int'(T_P96) * 2);
        serve = 1'b0;
        dis = 1'b1;
        cyc(int'(T_FI) / 2);
        dis = 1'b0;
        wait_oe(1'b1, p + 50, t_r);
        check_range(t_r - t_fall, p, p + 4);
        dis = 1'b1;
        wait_oe(1'b0, int'(T_AL) + 50, t_f);
        check_range(t_f - t_r, int'(T_AL), int'(T_AL));
        seen = n_rise;
        cyc(ig + int'(T_P96) * 2);
        check_range(n_rise - seen, 0, 0);
        check_bit(alarm_pin_n, 1'b1);
        t0 = cyc_cnt;
        dis = 1'b0;
        wait_oe(1'b1, int'(T_FI) + ig + p + 50, t_r);
        check_range(t_r - t0, int'(T_FI) + ig + p,
                    int'(T_FI) + ig + p + 8);
        wait_oe(1'b0, int'(T_AL) + 50, t_f);
        // A mid-run reset with strap a high must take the fast delay.
        sel_a = 1'b1;
        rst = 1'b1;
        cyc(2);
        check_bit(rst_oe, 1'b1);
        check_bit(alm_oe, 1'b0);
        rst = 1'b0;
        t0 = cyc_cnt;
        while (rst_oe !== 1'b0 && cyc_cnt - t0 < 2000)
            cyc(1);
        check_range(cyc_cnt - t0, int'(T_RF), int'(T_RF) + 3);
        conclude();
    end
endmodule

bind pwd_top pwd_top_assertions #(.RST_DLY_SLOW_CYC(RST_DLY_SLOW_CYC),
    .RST_DLY_FAST_CYC(RST_DLY_FAST_CYC), .IGNORE_CYC(IGNORE_CYC),
    .PERIOD_16_CYC(PERIOD_16_CYC), .ALARM_LOW_CYC(ALARM_LOW_CYC),
    .DIS_FILT_CYC(DIS_FILT_CYC)) pwd_top_assertions_i (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .trigger_in(trigger_in),
    .trigger_disable_in(trigger_disable_in),
    .period_select_a_in(period_select_a_in),
    .period_select_b_in(period_select_b_in),
    .alarm_out_n_in(alarm_out_n_in), .alarm_out_n_out(alarm_out_n_out),
    .alarm_out_n_oe_out(alarm_out_n_oe_out),
    .reset_out_n_out(reset_out_n_out),
    .reset_out_n_oe_out(reset_out_n_oe_out));

`default_nettype wire
